// ==== rtl/urx_receiver.sv ====
// Serial receive data recovery with address-frame filter, AXI4-Lite slave.
// Assumes an idle-high serial line from a remote transmitter, asynchronous
// to the system clock, and software that polls or takes the interrupt.
//
// Summary of operation
// - Sixteen samples per bit, eight at double speed
// - Bit level is majority of three samples
// - Voting samples start at 8, or 4
// - Frame ends at first stop bit
// - Low first stop bit sets frame error
// - Next start accepted right after stop vote
// - Filter mode drops frames without address
// - Filter setting gates stored frames and their interrupt events
// - Type bit: stop bit, or ninth bit
// - Type one means address, zero data
// - Start validated on samples 8-10 or 4-6
// - Double speed halves samples per bit
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps

module urx_receiver (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_input_pin,
   output logic irq
);

   // Majority of three samples
   function automatic logic majority3(input logic [2:0] s);
      majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : majority3

   // Byte-lane merge of a write into a register image
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction : merge

   // Registers that software writes
   logic [31:0] ctrl; // Enable, speed, filter, size
   logic [urx_pkg::BAUD_W-1:0] baudDivisorValue; // Sample tick divisor
   logic [urx_pkg::IRQ_W-1:0] irqMask; // Interrupt enables

   // Receiver state shown to software
   logic rxCompleteFlag; // Unread frame held
   logic frameErrorFlag; // Stop bit of held frame was low
   logic [8:0] rxData; // Held character
   logic [urx_pkg::IRQ_W-1:0] irqStatus; // Sticky events

   // Two-flop synchroniser; only rxSync is read by logic
   logic rxMeta;
   logic rxSync;

   // Recovery engine
   urx_pkg::urx_state_type state;
   logic [4:0] sampleNum; // Number of the last sample taken
   logic [3:0] bitIndex; // Data bit being received
   logic [1:0] votes; // First two voting samples
   logic [8:0] shiftReg; // Data bits gathered so far
   logic tick; // One sample period elapsed

   // AXI write bookkeeping
   logic awTaken;
   logic wTaken;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;

   // Configuration decode
   wire logic rxEnable = ctrl[urx_pkg::CTRL_ENABLE_BIT];
   wire logic doubleSpeedSelect = ctrl[urx_pkg::CTRL_DOUBLE_BIT];
   wire logic addressFilterEnable = ctrl[urx_pkg::CTRL_FILTER_BIT];
   wire logic [3:0] sizeCfg =
      ctrl[urx_pkg::CTRL_SIZE_LSB +: urx_pkg::CTRL_SIZE_W];
   // Out-of-range sizes clamp to the nearest legal one
   wire logic [3:0] charBits =
      (sizeCfg < urx_pkg::SIZE_MIN) ? urx_pkg::SIZE_MIN :
      (sizeCfg > urx_pkg::SIZE_MAX) ? urx_pkg::SIZE_MAX : sizeCfg;

   // Sampling plan for the selected speed
   wire logic [4:0] samplesPerBit = doubleSpeedSelect ?
      urx_pkg::SAMPLES_DOUBLE : urx_pkg::SAMPLES_NORMAL;
   wire logic [4:0] voteFirst = doubleSpeedSelect ?
      urx_pkg::VOTE_FIRST_DOUBLE : urx_pkg::VOTE_FIRST_NORMAL;
   wire logic [4:0] voteLast = voteFirst + 5'h02;
   wire logic [4:0] nextSample =
      (sampleNum >= samplesPerBit) ? 5'h01 : sampleNum + 5'h01;
   wire logic active = (state != urx_pkg::RX_IDLE);
   wire logic sampleTick = tick && active;
   wire logic collect = sampleTick && (nextSample >= voteFirst) &&
      (nextSample < voteLast);
   wire logic decide = sampleTick && (nextSample == voteLast);
   wire logic voteBit = majority3({votes, rxSync});
   wire logic startSeen = tick && !active && !rxSync;
   wire logic lastData = (bitIndex == charBits - 4'h1);
   wire logic stopDone = decide && (state == urx_pkg::RX_STOP);

   // Frame type bit and filter decision; the filter gates what is
   // stored and the interrupt events, both through accept
   wire logic frameType = (charBits == urx_pkg::SIZE_MAX) ?
      shiftReg[8] : voteBit;
   wire logic discard = addressFilterEnable && !frameType;
   wire urx_pkg::urx_frame_type frame = '{data: shiftReg,
      frameError: !voteBit, addressFrame: frameType};
   wire logic accept = stopDone && !discard;

   // AXI decode
   wire logic doWrite = awTaken && wTaken && !s_axi_bvalid;
   wire logic readTake = s_axi_arvalid && s_axi_arready;
   wire logic readsData = readTake && (s_axi_araddr == urx_pkg::ADDR_DATA);
   wire logic readsIrq = readTake &&
      (s_axi_araddr == urx_pkg::ADDR_IRQ_STATUS);
   wire logic wrCtrl = doWrite && (wrAddr == urx_pkg::ADDR_CTRL);
   wire logic wrBaud = doWrite && (wrAddr == urx_pkg::ADDR_BAUD);
   wire logic wrMask = doWrite && (wrAddr == urx_pkg::ADDR_IRQ_MASK);
   wire logic wrMapped = wrCtrl || wrBaud || wrMask ||
      (wrAddr == urx_pkg::ADDR_STATUS) || (wrAddr == urx_pkg::ADDR_DATA) ||
      (wrAddr == urx_pkg::ADDR_IRQ_STATUS);
   wire logic [31:0] mergedCtrl = merge(ctrl, wrData, wrStrb);
   wire logic [31:0] mergedBaud = merge({20'h0_0000, baudDivisorValue},
      wrData, wrStrb);
   wire logic [31:0] mergedMask = merge({30'h0, irqMask},
      wrData, wrStrb);
   wire logic [31:0] statusWord = {28'h000_0000, active,
      rxData[8], frameErrorFlag, rxCompleteFlag};
   localparam int IRQ_W_LOCAL = urx_pkg::IRQ_W;
   wire logic [IRQ_W_LOCAL-1:0] irqEvents = {accept && frame.frameError,
      accept};
   wire logic [31:0] readMux =
      (s_axi_araddr == urx_pkg::ADDR_CTRL) ? ctrl :
      (s_axi_araddr == urx_pkg::ADDR_BAUD) ?
         {20'h0_0000, baudDivisorValue} :
      (s_axi_araddr == urx_pkg::ADDR_STATUS) ? statusWord :
      (s_axi_araddr == urx_pkg::ADDR_DATA) ? {23'h0, rxData} :
      (s_axi_araddr == urx_pkg::ADDR_IRQ_STATUS) ?
         {30'h0, irqStatus} :
      (s_axi_araddr == urx_pkg::ADDR_IRQ_MASK) ?
         {30'h0, irqMask} : 32'h0000_0000;
   wire logic readMapped = (s_axi_araddr <= urx_pkg::ADDR_IRQ_MASK) &&
      (s_axi_araddr[1:0] == 2'h0);

   // Sample tick source
   urx_tick_gen #(
      .WIDTH(urx_pkg::BAUD_W)
   ) tickGen (
      .clock(clock),
      .rst(rst),
      .enable(rxEnable),
      .divisor(baudDivisorValue),
      .tick(tick)
   );

   // Pin synchroniser; the line idles high so reset holds it high
   always_ff @(posedge clock) begin
      if (rst) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
      end else begin
         rxMeta <= serial_input_pin;
         rxSync <= rxMeta;
      end
   end

   // Recovery sequence, stepped once per sample tick
   always_ff @(posedge clock) begin
      if (rst || !rxEnable) begin
         state <= urx_pkg::RX_IDLE;
         sampleNum <= 5'h00;
         bitIndex <= 4'h0;
         votes <= 2'h0;
         shiftReg <= 9'h000;
      end else if (startSeen) begin
         // First low sample is sample 1 of the start bit
         state <= urx_pkg::RX_START;
         sampleNum <= 5'h01;
         bitIndex <= 4'h0;
         shiftReg <= 9'h000; // Unused upper bits read as zero
      end else if (sampleTick) begin
         sampleNum <= nextSample;
         if (collect) begin
            votes <= {votes[0], rxSync};
         end
         if (decide) begin
            unique case (state)
               urx_pkg::RX_START: begin
                  // Majority high means a noise spike
                  state <= voteBit ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
               end
               urx_pkg::RX_DATA: begin
                  shiftReg[bitIndex] <= voteBit;
                  bitIndex <= bitIndex + 4'h1;
                  if (lastData) begin
                     state <= urx_pkg::RX_STOP;
                  end
               end
               urx_pkg::RX_STOP: begin
                  // Idle at once, so a start can follow the vote
                  state <= urx_pkg::RX_IDLE;
               end
               urx_pkg::RX_IDLE: begin
                  state <= urx_pkg::RX_IDLE;
               end
            endcase
         end
      end
   end

   // Held frame and its flags; a new frame wins over a read clear
   always_ff @(posedge clock) begin
      if (rst || !rxEnable) begin
         rxCompleteFlag <= 1'b0;
         frameErrorFlag <= 1'b0;
         rxData <= 9'h000;
      end else if (accept) begin
         // Discarded frames never get here
         rxCompleteFlag <= 1'b1;
         frameErrorFlag <= frame.frameError;
         rxData <= frame.data;
      end else if (readsData) begin
         rxCompleteFlag <= 1'b0;
      end
   end

   // Sticky interrupt status; read clears, a same-cycle event stays
   always_ff @(posedge clock) begin
      if (rst) begin
         irqStatus <= '0;
      end else begin
         irqStatus <= (readsIrq ? '0 : irqStatus) | irqEvents;
      end
   end

   // Interrupt level output
   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus & irqMask);
      end
   end

   // Software-written registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl <= urx_pkg::CTRL_RESET;
         baudDivisorValue <= urx_pkg::BAUD_RESET;
         irqMask <= urx_pkg::IRQ_MASK_RESET;
      end else begin
         if (wrCtrl) begin
            ctrl <= {25'h0, mergedCtrl[6:0]};
         end
         if (wrBaud) begin
            baudDivisorValue <= mergedBaud[urx_pkg::BAUD_W-1:0];
         end
         if (wrMask) begin
            irqMask <= mergedMask[urx_pkg::IRQ_W-1:0];
         end
      end
   end

   // Write channels: address and data taken in either order
   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= urx_pkg::RESP_OKAY;
         awTaken <= 1'b0;
         wTaken <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= 32'h0000_0000;
         wrStrb <= 4'h0;
      end else begin
         if (!awTaken && !s_axi_bvalid) begin
            s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
         end
         if (!wTaken && !s_axi_bvalid) begin
            s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
         end
         if (s_axi_awvalid && s_axi_awready) begin
            awTaken <= 1'b1;
            wrAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wTaken <= 1'b1;
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            // Unmapped addresses answer with an error, no effect
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? urx_pkg::RESP_OKAY :
               urx_pkg::RESP_SLVERR;
            awTaken <= 1'b0;
            wTaken <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read at a time, data registered
   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= urx_pkg::RESP_OKAY;
      end else if (readTake) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readMux;
         s_axi_rresp <= readMapped ? urx_pkg::RESP_OKAY :
            urx_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Checks on the recovery engine, the held frame and the interrupt output
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || !rxEnable);

   sequence lastSampleTick;
      sampleTick && !decide && !startSeen && (sampleNum == samplesPerBit);
   endsequence

   a_sample_wrap: assert property (
      lastSampleTick |=> sampleNum == 5'h01)
      else $error("sample count did not wrap at end of bit");

   a_double_count: assert property (
      doubleSpeedSelect && sampleTick && $stable(ctrl) |->
      nextSample <= 5'h08)
      else $error("double speed used more than eight samples");

   a_bit_vote: assert property (
      decide && state == urx_pkg::RX_DATA |=>
      shiftReg[$past(bitIndex)] == $past(voteBit))
      else $error("stored bit differs from majority vote");

   a_start_reject: assert property (
      decide && state == urx_pkg::RX_START && voteBit |=>
      state == urx_pkg::RX_IDLE)
      else $error("noisy start bit was not rejected");

   a_stop_idle: assert property (stopDone |=> !active)
      else $error("receiver not idle after stop bit vote");

   a_frame_error: assert property (
      accept |=> frameErrorFlag == !$past(voteBit) && rxCompleteFlag)
      else $error("frame error flag not equal to low stop bit");

   sequence droppedFrame;
      stopDone && discard;
   endsequence

   a_filter_drop: assert property (droppedFrame |=>
      $stable(frameErrorFlag) && $stable(rxData) &&
      (rxCompleteFlag == ($past(rxCompleteFlag) && !$past(readsData))))
      else $error("filtered frame changed receiver state");

   a_address_kept: assert property (
      stopDone && addressFilterEnable && frameType |=> rxCompleteFlag)
      else $error("address frame was dropped by the filter");

   a_irq_level: assert property (|(irqStatus & irqMask) |=> irq)
      else $error("interrupt not raised for unmasked status");

endmodule : urx_receiver

// ==== pkg/urx_pkg.sv ====
// Shared constants, types and field layout of the serial receive block.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package urx_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_DOUBLE_BIT = 1;
   localparam int CTRL_FILTER_BIT = 2;
   localparam int CTRL_SIZE_LSB = 3;
   localparam int CTRL_SIZE_W = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0040;

   // Baud divisor: one sample tick every (value + 1) clocks
   localparam int BAUD_W = 12;
   localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;

   // Status register fields
   localparam int STAT_COMPLETE_BIT = 0;
   localparam int STAT_FRAME_ERR_BIT = 1;
   localparam int STAT_NINTH_BIT = 2;
   localparam int STAT_BUSY_BIT = 3;

   // Interrupt status and mask fields
   localparam int IRQ_W = 2;
   localparam int IRQ_RX_BIT = 0;
   localparam int IRQ_FERR_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

   // Sampling plan of one bit, per speed mode
   localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
   localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
   localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
   localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;

   // Character size limits
   localparam logic [3:0] SIZE_MIN = 4'h5;
   localparam logic [3:0] SIZE_MAX = 4'h9;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Receiver sequence
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } urx_state_type;

   // One finished frame as it leaves the recovery logic
   typedef struct packed {
      logic [8:0] data;
      logic frameError;
      logic addressFrame;
   } urx_frame_type;

endpackage : urx_pkg

// ==== rtl/urx_tick_gen.sv ====
// Sample tick generator for the serial receiver.
// Assumes the divisor is static while the receiver is running.
`timescale 1ns/1ps

module urx_tick_gen #(
   parameter int WIDTH = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable,
   input wire logic [WIDTH-1:0] divisor,
   output logic tick
);

   logic [WIDTH-1:0] count; // Clocks left until the next tick

   // Down counter; a tick every divisor+1 clocks while enabled
   always_ff @(posedge clock) begin
      if (rst || !enable) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == '0) begin
         count <= divisor;
         tick <= 1'b1;
      end else begin
         count <= count - 1'b1;
         tick <= 1'b0;
      end
   end

endmodule : urx_tick_gen

// ==== testbench/urx_tx_model.sv ====
// Remote serial transmitter that drives the receiver's serial line.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps

module urx_tx_model #(
   parameter int SAMPLE_CLKS = 4 // Clocks per receiver sample tick
) (
   input wire logic clock,
   output logic line
);
   // Idle level of the line is high
   initial line = 1'b1;

   // Hold one level for some sample periods; one sample may be flipped
   task automatic hold(input logic lvl, input int smp, input int flip);
      for (int s = 1; s <= smp; s++) begin
         line <= (s == flip) ? ~lvl : lvl;
         repeat (SAMPLE_CLKS) @(posedge clock);
      end
   endtask : hold

   // One frame at the exact local rate, so this end uses none of
   // the shared error budget
   task automatic send(input logic [8:0] d, input int n, input int spb,
         input logic stopLvl, input int stopSmp, input int flip);
      hold(1'b0, spb, 0);
      for (int i = 0; i < n; i++) begin
         hold(d[i], spb, (i == 0) ? flip : 0);
      end
      hold(stopLvl, stopSmp, 0);
      // A low stop bit is followed by a return to idle
      if (stopLvl == 1'b0) begin
         line <= 1'b1;
         @(posedge clock);
      end
   endtask : send

   // Low pulse too short to pass as a start bit
   task automatic spike(input int smp);
      hold(1'b0, smp, 0);
      line <= 1'b1;
      @(posedge clock);
   endtask : spike
endmodule : urx_tx_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the serial receiver and its register bus.
// Assumes the transmitter model on the line and a 10 MHz clock.
`timescale 1ns/1ps

module tb_top;
   localparam int SCLK = 4; // Clocks per sample tick (divisor plus one)
   localparam logic [1:0] OK = urx_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = urx_pkg::RESP_SLVERR;
   localparam logic [7:0] A_CT = urx_pkg::ADDR_CTRL;
   localparam logic [7:0] A_ST = urx_pkg::ADDR_STATUS;
   localparam logic [7:0] A_DT = urx_pkg::ADDR_DATA;
   localparam logic [7:0] A_IS = urx_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] A_IM = urx_pkg::ADDR_IRQ_MASK;
   // Expected read result noted by the driver
   typedef struct {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0] r;
      string n;
   } urx_note_type;

   logic clock, rst, serialLine, irq;
   logic [7:0] awAddr, arAddr;
   logic [31:0] wData, rData;
   logic [3:0] wStrb;
   logic awValid, awReady, wValid, wReady, bValid, bReady;
   logic arValid, arReady, rValid, rReady;
   logic [1:0] bResp, rResp;
   logic [1:0] maskV; // Mask value software last wrote
   int fails = 0;
   int numChecks = 0;
   urx_note_type rdQ[$]; // Pending read expectations
   logic [1:0] wrQ[$]; // Pending write responses

   urx_receiver urx_receiver_i (.clock(clock), .rst(rst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .serial_input_pin(serialLine), .irq(irq));
   urx_tx_model #(.SAMPLE_CLKS(SCLK)) urx_tx_model_i (.clock(clock),
      .line(serialLine));

   // Free-running system clock, 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Shared value compare; an unknown never matches
   task automatic cmp(input string n, input logic [31:0] e,
         input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   // Results are matched with the oldest note at the handshake edge
   always @(posedge clock) begin
      if (rValid === 1'b1 && rReady === 1'b1) begin
         cmp(rdQ[0].n, rdQ[0].d & rdQ[0].m, rData & rdQ[0].m);
         cmp({rdQ[0].n, " resp"}, {30'h0, rdQ[0].r}, {30'h0, rResp});
         void'(rdQ.pop_front());
      end
      if (bValid === 1'b1 && bReady === 1'b1) begin
         cmp("write resp", {30'h0, wrQ[0]}, {30'h0, bResp});
         void'(wrQ.pop_front());
      end
   end

   // One write; address and data are offered together, each held
   // until its own ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] r);
      logic awDone, wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      wrQ.push_back(r);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge clock);
         if (awValid && awReady) awDone = 1'b1;
         if (wValid && wReady) wDone = 1'b1;
         awValid <= !awDone;
         wValid <= !wDone;
      end
      do @(posedge clock); while (bValid !== 1'b1);
      bReady <= 1'b0;
      // Spare edge so a following call never reassigns in this step
      @(posedge clock);
   endtask : wr

   // One read; the monitor compares the answer under mask m
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] m, input logic [1:0] r, input string n);
      rdQ.push_back('{d, m, r, n});
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do @(posedge clock); while (arReady !== 1'b1);
      arValid <= 1'b0;
      do @(posedge clock); while (rValid !== 1'b1);
      rReady <= 1'b0;
      @(posedge clock);
   endtask : rd

   // Send one frame, then check what software sees of it
   task automatic rx(input logic [8:0] d, input int n, input int spb,
         input logic stopLvl, input int flip, input logic kept);
      logic [31:0] st, ir;
      st = kept ? {28'h0, 1'b0, (n == 9) & d[8], ~stopLvl, 1'b1} : 32'h0;
      ir = kept ? {30'h0, ~stopLvl, 1'b1} : 32'h0;
      urx_tx_model_i.send(d, n, spb, stopLvl, spb, flip);
      // A low stop bit restarts the receiver on a false start; give it
      // a bit time to reject that before busy is looked at
      repeat (spb * SCLK) @(posedge clock);
      cmp("irq", {31'h0, |(ir[1:0] & maskV)}, {31'h0, irq});
      rd(A_ST, st, kept ? 32'hF : 32'h3, OK, "STATUS");
      rd(A_IS, ir, 32'h3, OK, "IRQ_STATUS");
      if (kept) begin
         rd(A_DT, {23'h0, d} & ((32'h1 << n) - 32'h1), 32'h1FF, OK,
            "DATA");
         rd(A_ST, 32'h0, 32'h1, OK, "STATUS");
      end
   endtask : rx

   // Wait a bounded time for the interrupt line
   task automatic waitIrq();
      // One edge first, so a level cleared by the last read has settled
      @(posedge clock);
      for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clock);
   endtask : waitIrq

   // Print the counts and the verdict, then stop
   task automatic close_out();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // Cut a hang short; the tests need about 10500 cycles
   initial begin
      repeat (60000) @(posedge clock);
      fails++;
      $display("watchdog expired");
      close_out();
   end

   // Main sequence
   initial begin
      logic [8:0] v;
      rst = 1'b1;
      {awAddr, arAddr, wData} = '0;
      {awValid, wValid, bReady, arValid, rReady} = '0;
      wStrb = 4'hF;
      maskV = 2'h0;
      v = 9'($urandom(32'hE957));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rd(A_CT, urx_pkg::CTRL_RESET, 32'hFFFF_FFFF, OK, "CTRL");
      rd(urx_pkg::ADDR_BAUD, 32'h0, 32'hFFF, OK, "BAUD");
      rd(A_ST, 32'h0, 32'hF, OK, "STATUS");
      rd(A_IM, 32'h0, 32'h3, OK, "IRQ_MASK");
      $display("test reset values done");
      rd(8'h20, 32'h0, 32'hFFFF_FFFF, ERR, "unmapped");
      rd(8'h02, 32'h0, 32'hFFFF_FFFF, ERR, "unaligned");
      wr(8'h18, 32'hFFFF, ERR);
      wr(A_ST, 32'hF, OK);
      rd(A_ST, 32'h0, 32'hF, OK, "STATUS");
      wr(urx_pkg::ADDR_BAUD, 32'(SCLK - 1), OK);
      rd(urx_pkg::ADDR_BAUD, 32'(SCLK - 1), 32'hFFF, OK, "BAUD");
      $display("test bus errors done");
      // Every size; the first frame arrives with interrupts masked
      for (int n = 5; n <= 9; n++) begin
         maskV = (n == 5) ? 2'h0 : 2'h3;
         wr(A_IM, {30'h0, maskV}, OK);
         rd(A_IM, {30'h0, maskV}, 32'h3, OK, "IRQ_MASK");
         wr(A_CT, 32'h1 | (32'(n) << 3), OK);
         rx(9'($urandom), n, 16, 1'b1, 0, 1'b1);
      end
      $display("test sizes done");
      wr(A_CT, 32'h41, OK);
      rx(9'($urandom), 8, 16, 1'b0, 0, 1'b1);
      $display("test frame error done");
      // One flipped centre sample in each speed mode
      for (int ds = 0; ds < 2; ds++) begin
         wr(A_CT, 32'h41 | (32'(ds) << 1), OK);
         rx(9'($urandom), 8, ds ? 8 : 16, 1'b1, ds ? 5 : 9, 1'b1);
      end
      $display("test voting done");
      wr(A_CT, 32'h41, OK);
      urx_tx_model_i.spike(7);
      repeat (20 * SCLK) @(posedge clock);
      rd(A_ST, 32'h0, 32'hF, OK, "STATUS");
      $display("test spike done");
      // Next start right after the last stop voting sample
      fork
         begin
            urx_tx_model_i.send(v, 8, 16, 1'b1, 10, 0);
            urx_tx_model_i.send(~v, 8, 16, 1'b1, 16, 0);
         end
         begin
            waitIrq();
            rd(A_DT, {24'h0, v[7:0]}, 32'h1FF, OK, "DATA A");
            rd(A_IS, 32'h1, 32'h3, OK, "IRQ_STATUS");
            waitIrq();
            rd(A_DT, {24'h0, ~v[7:0]}, 32'h1FF, OK, "DATA B");
            rd(A_IS, 32'h1, 32'h3, OK, "IRQ_STATUS");
         end
      join
      $display("test early start done");
      wr(A_CT, 32'h45, OK);
      rx(9'($urandom), 8, 16, 1'b0, 0, 1'b0);
      rx(9'($urandom), 8, 16, 1'b1, 0, 1'b1);
      wr(A_CT, 32'h4D, OK);
      rx({1'b0, v[7:0]}, 9, 16, 1'b1, 0, 1'b0);
      rx({1'b1, v[7:0]}, 9, 16, 1'b1, 0, 1'b1);
      // The selected node leaves filter mode itself
      wr(A_CT, 32'h49, OK);
      rx({1'b0, ~v[7:0]}, 9, 16, 1'b1, 0, 1'b1);
      $display("test address filter done");
      close_out();
   end
endmodule : tb_top
